// [tdh_pkg.sv]
// package for the transmit data-link message controller
// assumes a single core clock domain and a plain register port
package tdh_pkg;
   // ************************************************
   // register map
   // ************************************************
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] COUNT_ADDR = 4'h1;
   localparam logic [3:0] IRQ_STATUS_ADDR = 4'h2;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'h3;
   localparam logic [3:0] BUF0_ADDR = 4'h4;
   localparam logic [3:0] BUF1_ADDR = 4'h5;
   localparam logic [3:0] BUF_PTR_ADDR = 4'h6;
   // ************************************************
   // fields and reset values
   // ************************************************
   localparam int SEL_BIT = 0;
   localparam int FCS_BIT = 1;
   localparam int BUFSEL_BIT = 7;
   localparam int EOT_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] FLAG_OCTET = 8'h7E;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam int BUF_DEPTH = 128;
   localparam int STUFF_LIMIT = 5;
   localparam logic [2:0] STUFF_RUN = 3'h5;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tdh_req_t;

   typedef enum logic [0:0] {TDH_BOS, TDH_MOS} tdh_mode_t;
endpackage

// [tdh_serializer.sv]
// octet to bit serializer with optional zero insertion
// assumes one bit per clock; loads a new octet when ready
`timescale 1ns/1ns
module tdh_serializer (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // octet side
   input wire logic [7:0] octet,
   input wire logic stuff_en,
   output logic ready,
   // bit side
   output logic bit_out
);
   logic [7:0] shreg;
   logic [2:0] bitcnt;
   logic [2:0] ones;
   // stuffing follows the octet on the wire, not the one being offered
   logic cur_stuff;
   // ones only counts in stuffed octets, so a run of five ending a data
   // octet still gets its zero before a following flag
   wire insert_zero = (ones == tdh_pkg::STUFF_RUN);
   wire last_bit = (bitcnt == 3'h7) && !insert_zero;

   assign ready = last_bit;

   // zero after five ones, only in data and check octets
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         shreg <= tdh_pkg::FLAG_OCTET;
         bitcnt <= 3'h0;
         ones <= 3'h0;
         bit_out <= 1'b0;
         cur_stuff <= 1'b0;
      end else if (insert_zero) begin
         bit_out <= 1'b0;
         ones <= 3'h0;
      end else begin
         bit_out <= shreg[0];
         ones <= (shreg[0] && cur_stuff) ? ones + 3'h1 : 3'h0;
         cur_stuff <= last_bit ? stuff_en : cur_stuff;
         shreg <= last_bit ? octet : {1'b0, shreg[7:1]};
         bitcnt <= bitcnt + 3'h1;
      end
   end
endmodule // tdh_serializer

// [tdh_datalink_tx.sv]
// transmit data-link message controller: registers, ping-pong buffers, framer
// assumes host on a plain register port, one bit per core_clk to the link
// ************************************************
// ************************************************
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
module tdh_datalink_tx (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // interrupt
   output logic irq,
   // data-link channel
   output logic link_bit
);
   // ************************************************
   // registers
   // ************************************************
   typedef enum logic [2:0] {S_IDLE, S_OPEN, S_DATA, S_FCS_LO, S_FCS_HI, S_CLOSE} tdh_state_t;
   tdh_state_t state;
   tdh_pkg::tdh_req_t req;
   logic [7:0] ctrl;
   logic [6:0] tx_message_count;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [7:0] mem0 [0:tdh_pkg::BUF_DEPTH-1];
   logic [7:0] mem1 [0:tdh_pkg::BUF_DEPTH-1];
   logic [6:0] wptr0;
   logic [6:0] wptr1;
   logic busy;
   logic active_buf;
   logic tdh_mode;
   logic fcs_on;
   logic [6:0] len;
   logic [6:0] idx;
   logic [6:0] reps;
   logic [15:0] crc;
   logic eot_pulse;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   function automatic logic [15:0] crc_octet(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ tdh_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ************************************************
   // decode
   // ************************************************
   wire wr_ctrl = req.wr && (req.addr[3:0] == tdh_pkg::CTRL_ADDR);
   wire wr_count = req.wr && (req.addr[3:0] == tdh_pkg::COUNT_ADDR);
   wire wr_stat = req.wr && (req.addr[3:0] == tdh_pkg::IRQ_STATUS_ADDR);
   wire wr_mask = req.wr && (req.addr[3:0] == tdh_pkg::IRQ_MASK_ADDR);
   wire wr_buf0 = req.wr && (req.addr[3:0] == tdh_pkg::BUF0_ADDR);
   wire wr_buf1 = req.wr && (req.addr[3:0] == tdh_pkg::BUF1_ADDR);
   wire wr_ptr = req.wr && (req.addr[3:0] == tdh_pkg::BUF_PTR_ADDR);
   // a select written to the busy buffer is refused
   wire sel_req = reg_wdata[tdh_pkg::BUFSEL_BIT];
   wire sel_ok = !(busy && (sel_req == active_buf));
   wire start_req = wr_count && sel_ok;
   wire avail_buf = busy ? !active_buf : 1'b0;
   wire mos_sel = ctrl[tdh_pkg::SEL_BIT];
   wire fcs_sel = ctrl[tdh_pkg::FCS_BIT] && mos_sel;
   wire [7:0] cur_byte = active_buf ? mem1[idx] : mem0[idx];
   wire ser_ready;
   wire stuff_en = (state == S_DATA) || (state == S_FCS_LO) || (state == S_FCS_HI);
   wire [15:0] crc_fin = ~crc;
   logic [7:0] next_octet;
   always_comb begin
      case (state)
         S_DATA: next_octet = (tdh_mode == tdh_pkg::TDH_BOS) ? cur_byte : cur_byte;
         S_FCS_LO: next_octet = crc_fin[7:0];
         S_FCS_HI: next_octet = crc_fin[15:8];
         default: next_octet = tdh_pkg::FLAG_OCTET;
      endcase
   end

   wire [7:0] rd_mux =
      (req.addr[3:0] == tdh_pkg::CTRL_ADDR) ? ctrl :
      (req.addr[3:0] == tdh_pkg::COUNT_ADDR) ? {avail_buf, tx_message_count} :
      (req.addr[3:0] == tdh_pkg::IRQ_STATUS_ADDR) ? irq_status :
      (req.addr[3:0] == tdh_pkg::IRQ_MASK_ADDR) ? irq_mask :
      (req.addr[3:0] == tdh_pkg::BUF_PTR_ADDR) ? {1'b0, wptr0} : 8'h00;

   // ************************************************
   // host side registers
   // ************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= tdh_pkg::CTRL_RESET;
         tx_message_count <= tdh_pkg::COUNT_RESET[6:0];
         irq_mask <= 8'h00;
         irq_status <= 8'h00;
         reg_rdata <= 8'h00;
         irq <= 1'b0;
         wptr0 <= 7'h00;
         wptr1 <= 7'h00;
      end else begin
         if (wr_ctrl) ctrl <= {6'h00, reg_wdata[1:0]};
         if (wr_count) tx_message_count <= reg_wdata[6:0];
         if (wr_mask) irq_mask <= reg_wdata;
         // set wins over write-one-clear
         irq_status <= (irq_status & ~(wr_stat ? reg_wdata : 8'h00)) | {7'h00, eot_pulse};
         reg_rdata <= req.rd ? rd_mux : 8'h00;
         irq <= |(irq_status & irq_mask);
         if (wr_ptr) begin
            wptr0 <= 7'h00;
            wptr1 <= 7'h00;
         end
         if (wr_buf0) wptr0 <= wptr0 + 7'h01;
         if (wr_buf1) wptr1 <= wptr1 + 7'h01;
      end
   end

   // buffer storage, no reset on memory
   always_ff @(posedge core_clk) begin
      if (wr_buf0) mem0[wptr0] <= reg_wdata;
      if (wr_buf1) mem1[wptr1] <= reg_wdata;
   end

   // ************************************************
   // transmit sequencer
   // ************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         busy <= 1'b0;
         active_buf <= 1'b0;
         tdh_mode <= 1'b0;
         fcs_on <= 1'b0;
         len <= 7'h00;
         idx <= 7'h00;
         reps <= 7'h00;
         crc <= tdh_pkg::CRC_INIT;
         eot_pulse <= 1'b0;
      end else begin
         eot_pulse <= 1'b0;
         if (start_req && !busy) begin
            busy <= 1'b1;
            active_buf <= sel_req;
            tdh_mode <= mos_sel;
            fcs_on <= fcs_sel;
            len <= reg_wdata[6:0];
            reps <= 7'h00;
            idx <= 7'h00;
         end
         if (ser_ready) begin
            case (state)
               S_IDLE: begin
                  if (busy) state <= S_OPEN;
               end
               S_OPEN: begin
                  crc <= tdh_pkg::CRC_INIT;
                  idx <= 7'h00;
                  state <= (len == 7'h00) ? S_CLOSE : S_DATA;
               end
               S_DATA: begin
                  crc <= crc_octet(crc, cur_byte);
                  idx <= idx + 7'h01;
                  if (idx == len - 7'h01) state <= fcs_on ? S_FCS_LO : S_CLOSE;
               end
               S_FCS_LO: state <= S_FCS_HI;
               S_FCS_HI: state <= S_CLOSE;
               S_CLOSE: begin
                  state <= S_IDLE;
                  if (tdh_mode == tdh_pkg::TDH_MOS) begin
                     busy <= 1'b0;
                     eot_pulse <= 1'b1;
                  end else if (tx_message_count == 7'h00) begin
                     state <= S_OPEN;
                  end else if (reps + 7'h01 >= tx_message_count) begin
                     busy <= 1'b0;
                     eot_pulse <= 1'b1;
                  end else begin
                     reps <= reps + 7'h01;
                     state <= S_OPEN;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   tdh_serializer u_ser (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .octet(next_octet),
      .stuff_en(stuff_en),
      .ready(ser_ready),
      .bit_out(link_bit)
   );

   // ************************************************
   // checks
   // ************************************************
   sequence s_close_mos;
      ser_ready && state == S_CLOSE && tdh_mode == tdh_pkg::TDH_MOS;
   endsequence
   a_mos_end_irq: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_close_mos |=> eot_pulse && !busy) else $error("mos end without eot");
   a_fcs_ignored_bos: assert property (@(posedge core_clk) disable iff (!reset_n)
      (start_req && !busy && !mos_sel) |=> !fcs_on) else $error("fcs on in bos");
   a_fcs_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ser_ready && state == S_DATA && idx == len - 7'h01 && fcs_on) |=> state == S_FCS_LO)
      else $error("fcs not appended");
   a_no_fcs_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!fcs_on) |-> state != S_FCS_LO) else $error("fcs sent when off");
   a_avail_other: assert property (@(posedge core_clk) disable iff (!reset_n)
      (req.rd && req.addr[3:0] == tdh_pkg::COUNT_ADDR && busy)
      |=> reg_rdata[7] != active_buf) else $error("busy buffer reported free");
   a_inuse_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_count && busy) |=> $stable(active_buf)) else $error("busy buffer reselected");
   a_bos_forever: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ser_ready && state == S_CLOSE && tdh_mode == tdh_pkg::TDH_BOS
       && tx_message_count == 7'h00) |=> busy && !eot_pulse) else $error("bos stopped");
   a_bos_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ser_ready && state == S_CLOSE && tdh_mode == tdh_pkg::TDH_BOS && tx_message_count != 7'h00
       && reps + 7'h01 >= tx_message_count) |=> eot_pulse ##1 irq_status[0])
      else $error("bos count end missed");
   a_idle_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == S_IDLE) |-> next_octet == tdh_pkg::FLAG_OCTET) else $error("idle not flag");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
      |(irq_status & irq_mask) |=> irq) else $error("irq not raised");

   // ************************************************
   // step checks
   // ************************************************
   sequence s_start;
      start_req && !busy;
   endsequence
   sequence s_close_bos;
      ser_ready && state == S_CLOSE && tdh_mode == tdh_pkg::TDH_BOS;
   endsequence
   sequence s_data_last;
      ser_ready && state == S_DATA && idx == len - 7'h01;
   endsequence
   sequence s_open_step;
      ser_ready && state == S_OPEN;
   endsequence

   // start of a send
   a_start_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_start |=> busy && active_buf == $past(sel_req)) else $error("start not taken");
   a_start_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_start |=> tdh_mode == $past(mos_sel)) else $error("mode not latched");
   a_start_len: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_start |=> len == $past(reg_wdata[6:0])) else $error("length not latched");
   a_start_fcs: assert property (@(posedge core_clk) disable iff (!reset_n)
      (start_req && !busy && mos_sel && ctrl[tdh_pkg::FCS_BIT]) |=> fcs_on)
      else $error("check append lost");
   a_count_store: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_count |=> tx_message_count == $past(reg_wdata[6:0])) else $error("count not stored");
   a_ctrl_store: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_ctrl |=> ctrl[1:0] == $past(reg_wdata[1:0])) else $error("control not stored");

   // sequencer steps
   a_bos_repeat: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_close_bos ##0 (tx_message_count != 7'h00 && reps + 7'h01 < tx_message_count)
      |=> state == S_OPEN && busy && reps == $past(reps) + 7'h01) else $error("repeat lost");
   a_bos_endless: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_close_bos ##0 (tx_message_count == 7'h00) |=> state == S_OPEN)
      else $error("endless repeat stopped");
   a_mos_close: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_close_mos |=> state == S_IDLE) else $error("mos close not idle");
   a_open_crc: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_open_step |=> crc == tdh_pkg::CRC_INIT) else $error("check not preset");
   a_open_empty: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_open_step ##0 (len == 7'h00) |=> state == S_CLOSE) else $error("empty frame has data");
   a_data_octet: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ser_ready && state == S_DATA) |-> next_octet == cur_byte) else $error("wrong data octet");
   a_data_nofcs: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_data_last ##0 !fcs_on |=> state == S_CLOSE) else $error("no close after data");
   a_fcs_low: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == S_FCS_LO) |-> next_octet == ~crc[7:0]) else $error("wrong check octet");
   a_fcs_order: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ser_ready && state == S_FCS_LO) |=> state == S_FCS_HI) else $error("check order");
   a_close_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == S_CLOSE) |-> next_octet == tdh_pkg::FLAG_OCTET) else $error("close not flag");
   a_flag_unstuffed: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state == S_OPEN || state == S_IDLE || state == S_CLOSE) |-> !stuff_en)
      else $error("flag stuffed");
   a_busy_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      (busy && !(ser_ready && state == S_CLOSE)) |=> busy) else $error("busy dropped early");

   // status and read port
   a_eot_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
      eot_pulse |=> irq_status[0]) else $error("eot not latched");
   a_eot_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_stat && reg_wdata[0] && !eot_pulse) |=> !irq_status[0]) else $error("eot not cleared");
   a_irq_low: assert property (@(posedge core_clk) disable iff (!reset_n)
      !(|(irq_status & irq_mask)) |=> !irq) else $error("irq stuck");
   a_rdata_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      !req.rd |=> reg_rdata == 8'h00) else $error("read data not zero");
   a_idle_avail: assert property (@(posedge core_clk) disable iff (!reset_n)
      (req.rd && req.addr[3:0] == tdh_pkg::COUNT_ADDR && !busy) |=> reg_rdata[7] == 1'b0)
      else $error("idle avail not zero");
   a_ptr_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_ptr |=> wptr0 == 7'h00 && wptr1 == 7'h00) else $error("pointers not cleared");
endmodule // tdh_datalink_tx

// [tdh_link_model.sv]
// far-end receiver model: hunts flags, drops stuffed zeros, gathers octets
// assumes one link bit per core_clk, octets sent lsb first
`timescale 1ns/1ns
module tdh_link_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // link side
   input wire logic link_bit,
   // running frame and flag counts, and the length and data of the last frame
   output logic [15:0] frames,
   output logic [15:0] flags,
   output logic [7:0] frame_len,
   output logic [63:0] frame_data
);
   logic [7:0] raw;
   logic [7:0] dsh;
   logic [2:0] ones;
   logic [2:0] nb;
   logic [7:0] k;
   logic synced;
   wire logic [7:0] next_raw = {link_bit, raw[7:1]};
   wire logic is_flag = next_raw == 8'h7E;
   // zero after five ones is filler, never data
   wire logic drop = ones == 3'h5 && !link_bit;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         raw <= 8'h00;
         dsh <= 8'h00;
         ones <= 3'h0;
         nb <= 3'h0;
         k <= 8'h00;
         synced <= 1'b0;
         frames <= 16'h0000;
         flags <= 16'h0000;
         frame_len <= 8'h00;
         frame_data <= 64'h0;
      end else begin
         raw <= next_raw;
         ones <= link_bit ? ones + 3'h1 : 3'h0;
         if (is_flag) begin
            flags <= flags + 16'h0001;
            synced <= 1'b1;
            nb <= 3'h0;
            k <= 8'h00;
            if (synced && k != 8'h00) begin
               frames <= frames + 16'h0001;
               frame_len <= k;
            end
         end else if (!drop) begin
            nb <= nb + 3'h1;
            dsh <= {link_bit, dsh[7:1]};
            if (nb == 3'h7) begin
               k <= k + 8'h01;
               if (k < 8'h08) begin
                  frame_data[k[2:0]*8 +: 8] <= {link_bit, dsh[7:1]};
               end
            end
         end
      end
   end
endmodule // tdh_link_model

// [tb_top.sv]
// testbench for the transmit data-link message controller
// assumes the far-end model decodes the link; register port at 25 MHz
`timescale 1ns/1ns
module tb_top;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic irq;
   logic link_bit;
   logic [15:0] frames;
   logic [15:0] flags;
   logic [7:0] frame_len;
   logic [63:0] frame_data;
   logic [7:0] d;
   logic [15:0] c;
   logic [15:0] f0;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #20 core_clk = ~core_clk;
   tdh_datalink_tx i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .link_bit(link_bit));
   tdh_link_model i_far (.core_clk(core_clk), .reset_n(reset_n), .link_bit(link_bit),
      .frames(frames), .flags(flags), .frame_len(frame_len), .frame_data(frame_data));
   // ************************************************
   // access tasks
   // ************************************************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= {4'h0, a};
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= {4'h0, a};
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_eot;
      d = 8'h00;
      for (int i = 0; i < 400 && d[0] !== 1'b1; i++) rd(tdh_pkg::IRQ_STATUS_ADDR, d);
      chk(d[0], 1'b1);
      // closing flag lands a little after the status bit
      repeat (40) @(posedge core_clk);
   endtask
   function automatic logic [15:0] crc8(input logic [15:0] cr, input logic [7:0] b);
      for (int i = 0; i < 8; i++) cr = (cr[0] ^ b[i]) ? (cr >> 1) ^ tdh_pkg::CRC_POLY : cr >> 1;
      return cr;
   endfunction
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         finish_test;
      end
   end
   // ************************************************
   // tests
   // ************************************************
   initial begin
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (100) @(posedge core_clk);
      rd(tdh_pkg::CTRL_ADDR, d);
      chk(d, tdh_pkg::CTRL_RESET);
      rd(tdh_pkg::COUNT_ADDR, d);
      chk(d, tdh_pkg::COUNT_RESET);
      rd(4'hF, d);
      chk(d, 8'h00);
      chk(flags >= 16'd10 && frames == 16'h0, 1'b1);
      $display("test reset_idle done");
      wr(tdh_pkg::IRQ_MASK_ADDR, 8'h01);
      wr(tdh_pkg::BUF_PTR_ADDR, 8'h00);
      // ones-heavy octets force zero insertion
      wr(tdh_pkg::BUF0_ADDR, 8'hFF);
      wr(tdh_pkg::BUF0_ADDR, 8'h7E);
      wr(tdh_pkg::BUF0_ADDR, 8'h3C);
      wr(tdh_pkg::CTRL_ADDR, 8'h03);
      wr(tdh_pkg::COUNT_ADDR, 8'h03);
      rd(tdh_pkg::COUNT_ADDR, d);
      chk(d, 8'h83);
      wait_eot;
      c = ~crc8(crc8(crc8(tdh_pkg::CRC_INIT, 8'hFF), 8'h7E), 8'h3C);
      chk(frame_len, 8'h05);
      chk(frame_data[39:0], {c, 24'h3C7EFF});
      chk(irq, 1'b1);
      wr(tdh_pkg::IRQ_STATUS_ADDR, 8'h01);
      rd(tdh_pkg::COUNT_ADDR, d);
      chk(d[7], 1'b0);
      chk(irq, 1'b0);
      $display("test message_with_check done");
      wr(tdh_pkg::IRQ_MASK_ADDR, 8'h00);
      wr(tdh_pkg::BUF1_ADDR, 8'hA5);
      wr(tdh_pkg::BUF1_ADDR, 8'h0F);
      wr(tdh_pkg::CTRL_ADDR, 8'h01);
      wr(tdh_pkg::COUNT_ADDR, 8'h82);
      rd(tdh_pkg::COUNT_ADDR, d);
      chk(d[7], 1'b0);
      wait_eot;
      chk(frame_len, 8'h02);
      chk(frame_data[15:0], 16'h0FA5);
      chk(irq, 1'b0);
      wr(tdh_pkg::IRQ_STATUS_ADDR, 8'h01);
      $display("test message_no_check done");
      f0 = frames;
      wr(tdh_pkg::CTRL_ADDR, 8'h02);
      wr(tdh_pkg::COUNT_ADDR, 8'h02);
      wait_eot;
      chk(frames - f0, 16'h0002);
      repeat (300) @(posedge core_clk);
      chk(frames - f0, 16'h0002);
      $display("test bit_oriented_count done");
      wr(tdh_pkg::IRQ_STATUS_ADDR, 8'h01);
      f0 = frames;
      wr(tdh_pkg::CTRL_ADDR, 8'h00);
      wr(tdh_pkg::COUNT_ADDR, 8'h00);
      repeat (1500) @(posedge core_clk);
      rd(tdh_pkg::IRQ_STATUS_ADDR, d);
      chk(d[0], 1'b0);
      // count zero also gives a zero-length message, so only busy shows the repeat
      rd(tdh_pkg::COUNT_ADDR, d);
      chk(d, 8'h80);
      // a reset or a write of a nonzero count ends an endless repeat; a reset is used here
      reset_n <= 1'b0;
      @(posedge core_clk);
      reset_n <= 1'b1;
      rd(tdh_pkg::COUNT_ADDR, d);
      chk(d, tdh_pkg::COUNT_RESET);
      $display("test bit_oriented_endless done");
      finish_test;
   end
endmodule // tb_top
